//--- mac_regs_defines.vh
// Offsets, field positions, reset values and limits of the MAC control bank.
`ifndef MAC_REGS_DEFINES_VH
`define MAC_REGS_DEFINES_VH

`define ADDR_EEPROM_COMMAND 10'h14C
`define ADDR_MAC_CONTROL 10'h154
`define ADDR_COUNTER_DATA_WINDOW 10'h164
`define ADDR_COUNTER_SELECT_CONTROL 10'h168

`define EC_BUSY 8
`define EC_OP_HI 7
`define EC_OP_LO 6
`define EC_LOC_HI 5
`define EC_LOC_LO 0
`define EC_RESET 32'h00000000
`define EC_MASK 32'h000001FF

`define EEOP_ERASE 2'h3
`define EEOP_READ 2'h2
`define EEOP_WRITE 2'h1
`define EEOP_PROTECT 2'h0
`define EEPROT_ENABLE 2'h3
`define EEPROT_DISABLE 2'h0

`define MC_TX_RUN 27
`define MC_TX_PAUSE 26
`define MC_RX_RUN 25
`define MC_RX_PAUSE 24
`define MC_DROP_ERR 23
`define MC_KEEP_STATUS 22
`define MC_OVERSIZE_OK 21
`define MC_SOFT_REINIT 17
`define MC_LOOPBACK 16
`define MC_PAD_STRIP 7
`define MC_DUPLEX 6
`define MC_SQE 5
`define MC_DEFER_OFF 4
`define MC_FCS_STRIP 1
`define MC_FCS_CHECK_OFF 0
`define MC_RESET 32'h00800050
`define MC_MASK 32'h0FE300F3

`define CS_AUTO_INC 10
`define CS_CLEAR_ON_READ 9
`define CS_WRITE_MODE 8
`define CS_SEL_HI 5
`define CS_SEL_LO 0
`define CS_RESET 32'h00000000
`define CS_MASK 32'h0000073F

`define CNT_TX_LAST 6'h0E
`define CNT_RX_FIRST 6'h0F
`define CNT_LAST 6'h25
`define CNT_DEPTH 38

`endif

//--- rx_frame_verdict.v
// Per-frame receive verdict: bad marking, discard and status entry length.
`default_nettype none

module rx_frame_verdict (
  input wire clock,
  input wire rst_b,
  input wire frame_done,
  input wire frame_err,
  input wire frame_err_early,
  input wire frame_oversize,
  input wire [15:0] frame_len,
  input wire drop_err,
  input wire keep_status,
  input wire oversize_ok,
  output reg verdict_valid_ff,
  output reg frame_bad_ff,
  output reg frame_discard_ff,
  output reg status_push_ff,
  output reg [15:0] status_len_ff
);

  wire discard;
  wire bad;

  // Errors beyond the first 256 bytes come too late to drop the frame.
  assign discard = drop_err & frame_err & frame_err_early;
  assign bad = frame_err | (frame_oversize & ~oversize_ok);

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      verdict_valid_ff <= 1'b0;
      frame_bad_ff <= 1'b0;
      frame_discard_ff <= 1'b0;
      status_push_ff <= 1'b0;
      status_len_ff <= 16'h0000;
    end else begin
      verdict_valid_ff <= frame_done;
      if (frame_done) begin
        frame_bad_ff <= bad;
        frame_discard_ff <= discard;
        status_push_ff <= ~discard | keep_status;
        status_len_ff <= discard ? 16'h0000 : frame_len;
      end else begin
        status_push_ff <= 1'b0;
      end
    end
  end

endmodule // rx_frame_verdict

`default_nettype wire

//--- mac_prom_counter_ctrl_regs.v
// Host-visible EEPROM command, MAC control and statistics counter window.
`default_nettype none
`include "mac_regs_defines.vh"

module mac_prom_counter_ctrl_regs (
  input wire clock,
  input wire rst_b,
  input wire reg_cs,
  input wire reg_wr,
  input wire reg_rd,
  input wire [9:0] reg_addr,
  input wire [31:0] reg_wdata,
  output reg [31:0] reg_rdata_ff,
  input wire eeprom_done,
  output reg eeprom_start_ff,
  output wire [1:0] eeprom_op,
  output wire [5:0] eeprom_word_location,
  output reg eeprom_write_allowed_ff,
  input wire tx_in_frame,
  input wire rx_in_frame,
  output reg tx_go_ff,
  output reg rx_go_ff,
  output wire soft_reinitialise,
  output wire internal_loopback,
  output wire duplex_select,
  output wire sqe_check_on,
  output wire deferral_check_off,
  output wire rx_pad_strip,
  output wire rx_fcs_strip,
  output wire rx_fcs_check_off,
  input wire frame_done,
  input wire frame_err,
  input wire frame_err_early,
  input wire frame_oversize,
  input wire [15:0] frame_len,
  output wire verdict_valid,
  output wire frame_bad,
  output wire frame_discard,
  output wire status_push,
  output wire [15:0] status_len,
  input wire cnt_inc,
  input wire [5:0] cnt_inc_index,
  output reg cnt_inc_is_rx_ff
);

  reg [31:0] eeprom_command_ff;
  reg [31:0] nxt_eeprom_command;
  reg [31:0] mac_control_ff;
  reg [31:0] nxt_mac_control;
  reg [31:0] counter_select_control_ff;
  reg [31:0] nxt_counter_select_control;
  reg [31:0] counter_mem [0:`CNT_DEPTH-1];
  reg [31:0] nxt_rdata;
  reg nxt_start;
  reg nxt_write_allowed;
  integer i;

  wire wr_ec;
  wire wr_mc;
  wire wr_cdw;
  wire wr_csc;
  wire rd_cdw;
  wire [5:0] sel;
  wire sel_ok;
  wire inc_ok;
  wire busy;
  wire write_mode;
  wire window_read;
  wire window_write;
  wire [31:0] sel_value;
  wire auto_inc;
  wire clear_on_read;
  wire window_clear;

  // Decodes one register offset for one kind of access on the host bus.
  function bus_hit;
    input cs;
    input strobe;
    input [9:0] addr;
    input [9:0] target;
    begin
      bus_hit = cs & strobe & (addr == target);
    end
  endfunction

  // Only the decoded strobes are used; a miss simply reads as zero. A cycle
  // with both strobes high is a write only, so a read never clears a
  // counter that the same cycle is writing.
  assign wr_ec = bus_hit(reg_cs, reg_wr, reg_addr, `ADDR_EEPROM_COMMAND);
  assign wr_mc = bus_hit(reg_cs, reg_wr, reg_addr, `ADDR_MAC_CONTROL);
  assign wr_cdw = bus_hit(reg_cs, reg_wr, reg_addr,
                          `ADDR_COUNTER_DATA_WINDOW);
  assign wr_csc = bus_hit(reg_cs, reg_wr, reg_addr,
                          `ADDR_COUNTER_SELECT_CONTROL);
  assign rd_cdw = bus_hit(reg_cs, reg_rd & ~reg_wr, reg_addr,
                          `ADDR_COUNTER_DATA_WINDOW);

  assign busy = eeprom_command_ff[`EC_BUSY];
  assign eeprom_op = eeprom_command_ff[`EC_OP_HI:`EC_OP_LO];
  assign eeprom_word_location =
    eeprom_command_ff[`EC_LOC_HI:`EC_LOC_LO];

  assign sel = counter_select_control_ff[`CS_SEL_HI:`CS_SEL_LO];
  assign write_mode = counter_select_control_ff[`CS_WRITE_MODE];
  assign auto_inc = counter_select_control_ff[`CS_AUTO_INC];
  assign clear_on_read = counter_select_control_ff[`CS_CLEAR_ON_READ];

  // Returns one when the index names an implemented counter.
  function idx_ok;
    input [5:0] idx;
    begin
      idx_ok = (idx <= `CNT_LAST);
    end
  endfunction

  // Next index for auto increment. The last counter wraps to the first so
  // that a sweep of the whole bank needs no rewrite of the selector.
  function [5:0] next_sel;
    input [5:0] idx;
    begin
      if (idx >= `CNT_LAST) begin
        next_sel = 6'h00;
      end else begin
        next_sel = idx + 6'h01;
      end
    end
  endfunction

  // Returns one for an index in the receive part of the counter bank.
  function is_rx_index;
    input [5:0] idx;
    begin
      is_rx_index = (idx >= `CNT_RX_FIRST) && idx_ok(idx);
    end
  endfunction

  assign sel_ok = idx_ok(sel);
  assign inc_ok = cnt_inc & idx_ok(cnt_inc_index);
  assign sel_value = sel_ok ? counter_mem[sel] : 32'h00000000;

  // A read in write mode returns the value but has no side effect.
  assign window_read = rd_cdw & ~write_mode;
  assign window_write = wr_cdw & write_mode;
  assign window_clear = window_read & clear_on_read;

  assign soft_reinitialise = mac_control_ff[`MC_SOFT_REINIT];
  assign internal_loopback = mac_control_ff[`MC_LOOPBACK];
  assign duplex_select = mac_control_ff[`MC_DUPLEX];
  assign sqe_check_on = mac_control_ff[`MC_SQE];
  assign deferral_check_off = mac_control_ff[`MC_DEFER_OFF];
  assign rx_pad_strip = mac_control_ff[`MC_PAD_STRIP];
  assign rx_fcs_strip = mac_control_ff[`MC_FCS_STRIP];
  // Checking is turned off even when stripping is on; the host must avoid
  // that pairing, as the stripped check value is then never verified.
  assign rx_fcs_check_off = mac_control_ff[`MC_FCS_CHECK_OFF];

  // EEPROM command register and its start/busy handshake.
  always @* begin
    nxt_eeprom_command = eeprom_command_ff;
    nxt_start = 1'b0;
    nxt_write_allowed = eeprom_write_allowed_ff;
    if (busy && eeprom_done) begin
      nxt_eeprom_command[`EC_BUSY] = 1'b0;
      if (eeprom_op == `EEOP_PROTECT) begin
        if (eeprom_command_ff[5:4] == `EEPROT_ENABLE) begin
          nxt_write_allowed = 1'b1;
        end else if (eeprom_command_ff[5:4] == `EEPROT_DISABLE) begin
          nxt_write_allowed = 1'b0;
        end
      end
    end
    // Fields are frozen while a transfer runs so the EEPROM side never
    // sees a request change under it; such writes are dropped.
    if (wr_ec && (!busy || eeprom_done)) begin
      nxt_eeprom_command = reg_wdata & `EC_MASK;
      if (reg_wdata[`EC_BUSY]) begin
        nxt_start = 1'b1;
      end
    end
  end

  // MAC control register with the forced effect of soft reinitialise.
  always @* begin
    nxt_mac_control = mac_control_ff;
    if (wr_mc) begin
      nxt_mac_control = reg_wdata & `MC_MASK;
      if (reg_wdata[`MC_SOFT_REINIT]) begin
        nxt_mac_control[`MC_TX_PAUSE] = 1'b1;
        nxt_mac_control[`MC_RX_PAUSE] = 1'b1;
        nxt_mac_control[`MC_TX_RUN] = 1'b0;
        nxt_mac_control[`MC_RX_RUN] = 1'b0;
      end
    end
  end

  // Counter selection, advanced after each effective window access.
  always @* begin
    nxt_counter_select_control = counter_select_control_ff;
    if (wr_csc) begin
      nxt_counter_select_control = reg_wdata & `CS_MASK;
    end else if ((window_read || window_write) && auto_inc) begin
      nxt_counter_select_control[`CS_SEL_HI:`CS_SEL_LO] =
        next_sel(sel);
    end
  end

  // Read mux; reserved bits are masked out of every stored register.
  always @* begin
    nxt_rdata = reg_rdata_ff;
    if (reg_cs && reg_rd && !reg_wr) begin
      case (reg_addr)
        `ADDR_EEPROM_COMMAND: begin
          nxt_rdata = eeprom_command_ff;
        end
        `ADDR_MAC_CONTROL: begin
          nxt_rdata = mac_control_ff;
        end
        `ADDR_COUNTER_DATA_WINDOW: begin
          nxt_rdata = sel_value;
        end
        `ADDR_COUNTER_SELECT_CONTROL: begin
          nxt_rdata = counter_select_control_ff;
        end
        default: begin
          nxt_rdata = 32'h00000000;
        end
      endcase
    end
  end

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      eeprom_command_ff <= `EC_RESET;
      eeprom_start_ff <= 1'b0;
      eeprom_write_allowed_ff <= 1'b0;
      mac_control_ff <= `MC_RESET;
      counter_select_control_ff <= `CS_RESET;
      reg_rdata_ff <= 32'h00000000;
    end else begin
      eeprom_command_ff <= nxt_eeprom_command;
      eeprom_start_ff <= nxt_start;
      eeprom_write_allowed_ff <= nxt_write_allowed;
      mac_control_ff <= nxt_mac_control;
      counter_select_control_ff <= nxt_counter_select_control;
      reg_rdata_ff <= nxt_rdata;
    end
  end

  // Run gates. Clearing run drops the gate at once, even mid-frame.
  // Pause only drops it once the engine reports no frame in flight.
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tx_go_ff <= 1'b0;
      rx_go_ff <= 1'b0;
    end else begin
      tx_go_ff <= mac_control_ff[`MC_TX_RUN] &
                  (~mac_control_ff[`MC_TX_PAUSE] |
                   (tx_go_ff & tx_in_frame));
      rx_go_ff <= mac_control_ff[`MC_RX_RUN] &
                  (~mac_control_ff[`MC_RX_PAUSE] |
                   (rx_go_ff & rx_in_frame));
    end
  end

  // Statistics counters. An event that lands on the counter being
  // cleared by a read is kept as a count of one rather than lost.
  // A window write wins over an event on the same counter in that cycle.
  // Counters roll over at the top of their range; none saturates.
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      for (i = 0; i < `CNT_DEPTH; i = i + 1) begin
        counter_mem[i] <= 32'h00000000;
      end
      cnt_inc_is_rx_ff <= 1'b0;
    end else begin
      // An event on an unused index is ignored and leaves the side as is.
      if (inc_ok) begin
        cnt_inc_is_rx_ff <= is_rx_index(cnt_inc_index);
      end
      for (i = 0; i < `CNT_DEPTH; i = i + 1) begin
        if (sel_ok && (sel == i[5:0]) && window_write) begin
          counter_mem[i] <= reg_wdata;
        end else if (sel_ok && (sel == i[5:0]) && window_clear) begin
          if (inc_ok && (cnt_inc_index == i[5:0])) begin
            counter_mem[i] <= 32'h00000001;
          end else begin
            counter_mem[i] <= 32'h00000000;
          end
        end else if (inc_ok && (cnt_inc_index == i[5:0])) begin
          counter_mem[i] <= counter_mem[i] + 32'h00000001;
        end
      end
    end
  end

  rx_frame_verdict u_verdict (
    .clock(clock),
    .rst_b(rst_b),
    .frame_done(frame_done),
    .frame_err(frame_err),
    .frame_err_early(frame_err_early),
    .frame_oversize(frame_oversize),
    .frame_len(frame_len),
    .drop_err(mac_control_ff[`MC_DROP_ERR]),
    .keep_status(mac_control_ff[`MC_KEEP_STATUS]),
    .oversize_ok(mac_control_ff[`MC_OVERSIZE_OK]),
    .verdict_valid_ff(verdict_valid),
    .frame_bad_ff(frame_bad),
    .frame_discard_ff(frame_discard),
    .status_push_ff(status_push),
    .status_len_ff(status_len)
  );

endmodule // mac_prom_counter_ctrl_regs

`default_nettype wire

//--- mac_regs_chk.sv
// Port-level assertions for the MAC control register bank.
`default_nettype none
`include "mac_regs_defines.vh"
module mac_regs_chk (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic reg_cs,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [9:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata_ff,
  input wire logic eeprom_start_ff,
  input wire logic [1:0] eeprom_op,
  input wire logic [5:0] eeprom_word_location,
  input wire logic soft_reinitialise,
  input wire logic internal_loopback,
  input wire logic tx_go_ff,
  input wire logic rx_go_ff,
  input wire logic frame_done,
  input wire logic frame_err,
  input wire logic frame_err_early,
  input wire logic verdict_valid,
  input wire logic frame_discard,
  input wire logic status_push,
  input wire logic cnt_inc,
  input wire logic [5:0] cnt_inc_index,
  input wire logic cnt_inc_is_rx_ff
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  wire logic ec_wr = reg_cs && reg_wr && reg_addr == `ADDR_EEPROM_COMMAND;
  wire logic mc_wr = reg_cs && reg_wr && reg_addr == `ADDR_MAC_CONTROL;
  start_cause_a: assert property (eeprom_start_ff |->
    $past(ec_wr && reg_wdata[8]))
    else $error("start pulse without a start write");
  start_fields_a: assert property (eeprom_start_ff |->
    eeprom_op == $past(reg_wdata[7:6]) &&
    eeprom_word_location == $past(reg_wdata[5:0]))
    else $error("command fields differ from the start write");
  reinit_stop_a: assert property ($rose(soft_reinitialise) |=>
    !tx_go_ff && !rx_go_ff) else $error("engines still run after reinit");
  loop_cause_a: assert property ($rose(internal_loopback) |->
    $past(mc_wr && reg_wdata[16])) else $error("loopback set without write");
  verdict_time_a: assert property (frame_done |=> verdict_valid)
    else $error("verdict missing after frame end");
  discard_cause_a: assert property (verdict_valid && frame_discard
    |-> $past(frame_err && frame_err_early))
    else $error("discard without error");
  kept_entry_a: assert property (verdict_valid && !frame_discard |->
    status_push) else $error("kept frame got no status entry");
  counter_side_a: assert property ($past(cnt_inc) &&
    $past(cnt_inc_index) <= 6'h25 |->
    cnt_inc_is_rx_ff == ($past(cnt_inc_index) >= 6'h0F))
    else $error("counter side wrong");
  rdata_hold_a: assert property (
    !$past(reg_cs && reg_rd && !reg_wr) |-> $stable(reg_rdata_ff))
    else $error("read data moved without a read");
endmodule // mac_regs_chk
bind mac_prom_counter_ctrl_regs mac_regs_chk chk_i (
  .clock(clock), .rst_b(rst_b), .reg_cs(reg_cs), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata_ff(reg_rdata_ff), .eeprom_start_ff(eeprom_start_ff),
  .eeprom_op(eeprom_op), .eeprom_word_location(eeprom_word_location),
  .soft_reinitialise(soft_reinitialise),
  .internal_loopback(internal_loopback), .tx_go_ff(tx_go_ff),
  .rx_go_ff(rx_go_ff), .frame_done(frame_done), .frame_err(frame_err),
  .frame_err_early(frame_err_early), .verdict_valid(verdict_valid),
  .frame_discard(frame_discard), .status_push(status_push),
  .cnt_inc(cnt_inc), .cnt_inc_index(cnt_inc_index),
  .cnt_inc_is_rx_ff(cnt_inc_is_rx_ff)
);
`default_nettype wire

//--- eeprom_model.sv
// Behavioural serial EEPROM engine that answers each start pulse.
`default_nettype none
module eeprom_model #(
  parameter int LATENCY = 12
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic eeprom_start_ff,
  output var logic eeprom_done
);
  timeunit 1ns;
  timeprecision 1ns;
  int left = 0;
  initial eeprom_done = 1'b0;
  // Every opcode takes the same time here, which a real part would not.
  always @(posedge clock) begin
    #1;
    eeprom_done = (left == 1);
    if (left != 0) left = left - 1;
    if (eeprom_start_ff) left = LATENCY;
    if (!rst_b) left = 0;
  end
endmodule // eeprom_model
`default_nettype wire

//--- mac_prom_counter_ctrl_regs_test.sv
// Self-checking bench for the MAC control register bank.
`default_nettype none
`include "mac_regs_defines.vh"
module mac_prom_counter_ctrl_regs_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [9:0] EC = `ADDR_EEPROM_COMMAND;
  localparam logic [9:0] MC = `ADDR_MAC_CONTROL;
  localparam logic [9:0] WN = `ADDR_COUNTER_DATA_WINDOW;
  localparam logic [9:0] CS = `ADDR_COUNTER_SELECT_CONTROL;
  logic clock, rst_b, reg_cs, reg_wr, reg_rd, eeprom_done, eeprom_start_ff;
  logic tx_in_frame, rx_in_frame, frame_done, frame_err, frame_err_early;
  logic frame_oversize, cnt_inc, write_ok, tx_go_ff, rx_go_ff, verdict_valid;
  logic frame_bad, frame_discard, status_push, cnt_inc_is_rx_ff;
  logic [9:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata_ff, r;
  logic [15:0] frame_len, status_len;
  logic [5:0] cnt_inc_index, loc;
  logic [1:0] op;
  logic [7:0] flags;
  logic [7:0] ee [5] = '{8'hD5, 8'hAA, 8'h7F, 8'h30, 8'h00};
  int failures = 0;
  int compares = 0;
  int starts = 0;
  int i, n;
  mac_prom_counter_ctrl_regs dut (.clock(clock), .rst_b(rst_b),
    .reg_cs(reg_cs), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff),
    .eeprom_done(eeprom_done), .eeprom_start_ff(eeprom_start_ff),
    .eeprom_op(op), .eeprom_word_location(loc),
    .eeprom_write_allowed_ff(write_ok), .tx_in_frame(tx_in_frame),
    .rx_in_frame(rx_in_frame), .tx_go_ff(tx_go_ff), .rx_go_ff(rx_go_ff),
    .soft_reinitialise(flags[7]), .internal_loopback(flags[6]),
    .duplex_select(flags[5]), .sqe_check_on(flags[4]),
    .deferral_check_off(flags[3]), .rx_pad_strip(flags[2]),
    .rx_fcs_strip(flags[1]), .rx_fcs_check_off(flags[0]),
    .frame_done(frame_done), .frame_err(frame_err),
    .frame_err_early(frame_err_early), .frame_oversize(frame_oversize),
    .frame_len(frame_len), .verdict_valid(verdict_valid),
    .frame_bad(frame_bad), .frame_discard(frame_discard),
    .status_push(status_push), .status_len(status_len), .cnt_inc(cnt_inc),
    .cnt_inc_index(cnt_inc_index), .cnt_inc_is_rx_ff(cnt_inc_is_rx_ff));
  eeprom_model partner (.clock(clock), .rst_b(rst_b),
    .eeprom_start_ff(eeprom_start_ff), .eeprom_done(eeprom_done));
  // Start pulses are counted so that refused commands can be seen.
  always @(posedge clock) begin
    if (eeprom_start_ff === 1'b1) starts++;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clock) #1;
  endtask
  // Every access ends with an idle cycle so strobes never retoggle at once.
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    {reg_cs, reg_wr, reg_addr, reg_wdata} = {2'b11, a, d};
    cyc(1);
    {reg_cs, reg_wr} = 2'b00;
    cyc(1);
  endtask
  task automatic rd(input logic [9:0] a, output logic [31:0] v);
    {reg_cs, reg_rd, reg_addr} = {2'b11, a};
    cyc(1);
    {reg_cs, reg_rd} = 2'b00;
    cyc(1);
    v = reg_rdata_ff;
  endtask
  task automatic frm(input logic [31:0] mc, input logic [2:0] f,
                     input logic [3:0] e, input logic [15:0] len);
    wr(MC, mc);
    {frame_err, frame_err_early, frame_oversize, frame_done} = {f, 1'b1};
    cyc(1);
    frame_done = 1'b0;
    chk({verdict_valid, frame_bad, frame_discard, status_push}, e);
    chk(status_len, len);
    cyc(1);
  endtask
  task automatic cnt(input logic [5:0] idx, input logic side);
    {cnt_inc, cnt_inc_index} = {1'b1, idx};
    cyc(1);
    cnt_inc = 1'b0;
    cyc(1);
    chk(cnt_inc_is_rx_ff, side);
  endtask
  task automatic close_out;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  initial begin
    #(4000 * 50);
    failures++;
    close_out();
  end
  initial begin
    {rst_b, reg_cs, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    {tx_in_frame, rx_in_frame, frame_done, frame_err} = '0;
    {frame_err_early, frame_oversize, cnt_inc, cnt_inc_index} = '0;
    frame_len = 16'h0064;
    repeat (4) @(posedge clock);
    #1 rst_b = 1'b1;
    cyc(1);
    rd(EC, r);
    chk(r, `EC_RESET);
    rd(MC, r);
    chk(r, `MC_RESET);
    chk(flags, 8'h28);
    wr(MC, 32'hFFFFFFFE);
    rd(MC, r);
    chk(r, 32'h05E300F2);
    chk({flags, tx_go_ff, rx_go_ff}, 10'h3F8);
    wr(MC, 32'h0A000001);
    chk({flags, tx_go_ff, rx_go_ff}, 10'h007);
    {tx_in_frame, rx_in_frame} = 2'b11;
    wr(MC, 32'h0F000000);
    cyc(2);
    chk({tx_go_ff, rx_go_ff}, 2'h3);
    {tx_in_frame, rx_in_frame} = 2'b00;
    cyc(2);
    chk({tx_go_ff, rx_go_ff}, 2'h0);
    wr(MC, 32'h0A000000);
    {tx_in_frame, rx_in_frame} = 2'b11;
    cyc(1);
    chk({tx_go_ff, rx_go_ff}, 2'h3);
    wr(MC, 32'h00000000);
    cyc(1);
    chk({tx_go_ff, rx_go_ff}, 2'h0);
    wr(MC, 32'h0A000000);
    wr(MC, 32'h0A020000);
    chk({tx_go_ff, rx_go_ff}, 2'h0);
    {tx_in_frame, rx_in_frame} = 2'b00;
    for (i = 0; i < 5; i++) begin
      wr(EC, {23'h0, 1'b1, ee[i]});
      rd(EC, r);
      chk(r, {23'h0, 1'b1, ee[i]});
      chk({op, loc}, ee[i]);
      wr(EC, 32'h000001C0);
      chk({op, loc}, ee[i]);
      for (n = 0; n < 40 && r[8] !== 1'b0; n++) rd(EC, r);
      chk(r, {24'h0, ee[i]});
      chk(write_ok, i == 3);
    end
    chk(starts, 5);
    frm(32'h00C00000, 3'b110, 4'b1111, 16'h0000);
    frm(32'h00800000, 3'b110, 4'b1110, 16'h0000);
    frm(32'h00000000, 3'b110, 4'b1101, 16'h0064);
    frm(32'h00800000, 3'b100, 4'b1101, 16'h0064);
    frm(32'h00000000, 3'b001, 4'b1101, 16'h0064);
    frm(32'h00200000, 3'b001, 4'b1001, 16'h0064);
    cnt(6'h0F, 1'b1);
    cnt(6'h0E, 1'b0);
    cnt(6'h0E, 1'b0);
    cnt(6'h0E, 1'b0);
    cnt(6'h26, 1'b0);
    wr(CS, 32'h0000060E);
    rd(WN, r);
    chk(r, 32'h3);
    rd(WN, r);
    chk(r, 32'h1);
    wr(CS, 32'h0000000E);
    rd(WN, r);
    chk(r, 32'h0);
    wr(CS, 32'hFFFFFFFF);
    rd(CS, r);
    chk(r, `CS_MASK);
    wr(CS, 32'h00000125);
    wr(WN, 32'hA5A5A5A5);
    wr(CS, 32'h00000025);
    wr(WN, 32'h12345678);
    rd(WN, r);
    chk(r, 32'hA5A5A5A5);
    rd(10'h100, r);
    chk(r, 32'h0);
    close_out();
  end
endmodule // mac_prom_counter_ctrl_regs_test
`default_nettype wire
